/* design/slpreg_pkg.sv */
// Constants for the sleep, regulator and two-speed start controller
// Operation
// - Low-power select set puts regulator in standby during sleep, else normal
// - Bits 6 and 3 read zero; writes to them do nothing
// - Bit 5 is read-only wake comparator output
// - Comparator level and sink bits meaningless unless wake enable set
// - Bit 2 enables wake unit and routes comparator to level bit
// - Bit 1 drives wake current sink; resets to zero
// - Bit 0 turns watchdog on; ignored when configuration enables it
// - Bit 4 with keepalive config zero and regulator on selects ultra-low-power sleep
// - Keepalive select only available when strap is 1 and config is 0
// - Mode decode: ultra-low-power overrides low-power select, else select chooses
// - Ultra-low-power sleep drops references unless brown-out or low-voltage detect
// - Wake from ultra-low-power sleep waits about 250 us before running
// - Two-speed start only active when its enable bit is set
// - Reset or wake runs from internal oscillator while crystal timer counts
// - Crystal timer expiry switches clock to primary and enters primary run
// - Other power-managed modes ignore two-speed enable, keep selected source
// - Regulator enable comes from strap only; no software override
// - Software watchdog enable overrides only a disabled configuration
// - Primary clock ready status set on primary, clear on internal oscillator
package slpreg_pkg;
    localparam logic [7:0] SLPREG_CTRL_ADDR   = 8'h00;
    localparam logic [7:0] SLPREG_STATUS_ADDR = 8'h04;
    localparam logic [7:0] SLPREG_CTRL_WMASK  = 8'h97;
    localparam logic [7:0] SLPREG_CTRL_RESET  = 8'h00;
    localparam int         SLPREG_BIT_LOWPWR  = 7;
    localparam int         SLPREG_BIT_LEVEL   = 5;
    localparam int         SLPREG_BIT_KEEP    = 4;
    localparam int         SLPREG_BIT_WAKEEN  = 2;
    localparam int         SLPREG_BIT_SINK    = 1;
    localparam int         SLPREG_BIT_SWDT    = 0;
    localparam int         SLPREG_CLK_MHZ     = 250;
    localparam int         SLPREG_WAKE_US     = 250;
    localparam int         SLPREG_WAKE_CYC    = SLPREG_WAKE_US * SLPREG_CLK_MHZ;
    localparam int         SLPREG_CNT_W       = 17;
    localparam logic [1:0] SLPREG_WDT_SOFT    = 2'b00;
    typedef enum logic [1:0] {
        SLPREG_REG_NORMAL,
        SLPREG_REG_LOWPWR,
        SLPREG_REG_ULTRA
    } slpreg_mode_e;
    typedef enum logic [2:0] {
        SLPREG_RUN_PRI,
        SLPREG_RUN_INT,
        SLPREG_SLEEP,
        SLPREG_WAKE_WAIT
    } slpreg_state_e;
endpackage

/* design/slpreg_counter.sv */
// Load-and-count-down delay counter with done flag
`timescale 1ns/1ps
module slpreg_counter
    import slpreg_pkg::*;
(
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    input  wire logic                    load,
    input  wire logic [SLPREG_CNT_W-1:0] load_value,
    output logic                         busy,
    output logic                         done
);
    typedef struct packed {
        logic [SLPREG_CNT_W-1:0] count;
        logic                    busy;
        logic                    done;
    } slpreg_cnt_s;
    slpreg_cnt_s r;
    slpreg_cnt_s next_r;

    always_comb begin
        next_r      = r;
        next_r.done = 1'b0;
        if (load) begin
            next_r.count = load_value;
            next_r.busy  = 1'b1;
        end else if (r.busy) begin
            if (r.count <= SLPREG_CNT_W'(1)) begin
                next_r.busy = 1'b0;
                next_r.done = 1'b1;
            end else begin
                next_r.count = r.count - SLPREG_CNT_W'(1);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign busy = r.busy;
    assign done = r.done;
endmodule

/* design/slpreg_top.sv */
// Sleep, regulator mode and two-speed start controller with APB register access
`timescale 1ns/1ps
module slpreg_top
    import slpreg_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        regulator_enable_strap,
    input  wire logic        keepalive_regulator_config,
    input  wire logic [1:0]  watchdog_config_mode,
    input  wire logic        two_speed_start_enable,
    input  wire logic        brownout_reset_enable,
    input  wire logic        low_voltage_detect_enable,
    input  wire logic        wake_comparator_in,
    input  wire logic        sleep_request,
    input  wire logic        wake_event,
    input  wire logic        reset_start,
    input  wire logic        power_managed_mode,
    input  wire logic        crystal_startup_timer_done,
    output logic             watchdog_enable,
    output logic             wake_current_sink_enable,
    output logic             ultralow_wake_unit_enable,
    output logic             regulator_standby,
    output logic             regulator_ultralow,
    output logic             references_on,
    output logic             internal_oscillator_select,
    output logic             primary_clock_ready_status,
    output logic             core_run,
    output logic             in_sleep
);
    typedef struct packed {
        logic [7:0]    ctrl;
        logic          level;
        slpreg_mode_e  mode;
        slpreg_state_e state;
    } slpreg_top_s;

    slpreg_top_s r;
    slpreg_top_s next_r;
    logic        wr_en;
    logic        keep_avail;
    slpreg_mode_e mode_decode;
    logic        cnt_load;
    logic        cnt_busy;
    logic        cnt_done;
    logic [7:0]  ctrl_view;

    assign wr_en = psel && penable && pwrite && (paddr == SLPREG_CTRL_ADDR);

    // Keepalive only meaningful with strap set and keepalive config clear
    assign keep_avail = regulator_enable_strap && !keepalive_regulator_config;

    always_comb begin
        if (r.ctrl[SLPREG_BIT_KEEP] && keep_avail) begin
            mode_decode = SLPREG_REG_ULTRA;
        end else if (r.ctrl[SLPREG_BIT_LOWPWR]) begin
            mode_decode = SLPREG_REG_LOWPWR;
        end else begin
            mode_decode = SLPREG_REG_NORMAL;
        end
    end

    slpreg_counter u_wake_delay (
        .pclk       (pclk),
        .presetn    (presetn),
        .load       (cnt_load),
        .load_value (SLPREG_CNT_W'(SLPREG_WAKE_CYC)),
        .busy       (cnt_busy),
        .done       (cnt_done)
    );

    always_comb begin
        next_r   = r;
        cnt_load = 1'b0;
        if (wr_en) begin
            next_r.ctrl = pwdata[7:0] & SLPREG_CTRL_WMASK;
        end
        // Level tracks comparator only while the wake unit runs
        if (r.ctrl[SLPREG_BIT_WAKEEN]) begin
            next_r.level = wake_comparator_in;
        end else begin
            next_r.level = 1'b0;
        end
        case (r.state)
            SLPREG_RUN_PRI: begin
                if (sleep_request) begin
                    next_r.mode  = mode_decode;
                    next_r.state = SLPREG_SLEEP;
                end else if (reset_start && two_speed_start_enable) begin
                    next_r.state = SLPREG_RUN_INT;
                end
            end
            SLPREG_RUN_INT: begin
                if (sleep_request) begin
                    next_r.mode  = mode_decode;
                    next_r.state = SLPREG_SLEEP;
                end else if (crystal_startup_timer_done) begin
                    next_r.state = SLPREG_RUN_PRI;
                end
            end
            SLPREG_SLEEP: begin
                if (wake_event) begin
                    if (r.mode == SLPREG_REG_ULTRA) begin
                        cnt_load     = 1'b1;
                        next_r.state = SLPREG_WAKE_WAIT;
                    end else if (two_speed_start_enable && !power_managed_mode) begin
                        next_r.state = SLPREG_RUN_INT;
                    end else begin
                        next_r.state = SLPREG_RUN_PRI;
                    end
                end
            end
            SLPREG_WAKE_WAIT: begin
                if (cnt_done) begin
                    if (two_speed_start_enable && !power_managed_mode) begin
                        next_r.state = SLPREG_RUN_INT;
                    end else begin
                        next_r.state = SLPREG_RUN_PRI;
                    end
                end
            end
            default: begin
                next_r.state = SLPREG_RUN_PRI;
            end
        endcase
    end

    // Reset always loads primary run; reset_start with two-speed start then enters internal run
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r.ctrl  <= SLPREG_CTRL_RESET;
            r.level <= 1'b0;
            r.mode  <= SLPREG_REG_NORMAL;
            r.state <= SLPREG_RUN_PRI;
        end else begin
            r <= next_r;
        end
    end

    always_comb begin
        ctrl_view                   = r.ctrl;
        ctrl_view[SLPREG_BIT_LEVEL] = r.level;
    end

    // Single-cycle access, never waits
    assign pready  = 1'b1;
    assign pslverr = psel && penable && (paddr != SLPREG_CTRL_ADDR)
                     && (paddr != SLPREG_STATUS_ADDR);

    always_comb begin
        prdata = 32'h0000_0000;
        if (paddr == SLPREG_CTRL_ADDR) begin
            prdata[7:0] = ctrl_view;
        end else if (paddr == SLPREG_STATUS_ADDR) begin
            prdata[0] = primary_clock_ready_status;
            prdata[1] = in_sleep;
            prdata[3:2] = r.mode;
        end
    end

    // Software enable only counts when configuration leaves the watchdog off
    assign watchdog_enable = (watchdog_config_mode != SLPREG_WDT_SOFT)
                             || r.ctrl[SLPREG_BIT_SWDT];
    assign wake_current_sink_enable  = r.ctrl[SLPREG_BIT_SINK];
    assign ultralow_wake_unit_enable = r.ctrl[SLPREG_BIT_WAKEEN];
    assign in_sleep           = (r.state == SLPREG_SLEEP);
    assign regulator_standby  = in_sleep && (r.mode == SLPREG_REG_LOWPWR);
    assign regulator_ultralow = in_sleep && (r.mode == SLPREG_REG_ULTRA);
    assign references_on      = !regulator_ultralow || brownout_reset_enable
                                || low_voltage_detect_enable;
    assign internal_oscillator_select = (r.state == SLPREG_RUN_INT);
    assign primary_clock_ready_status = (r.state == SLPREG_RUN_PRI);
    assign core_run = (r.state == SLPREG_RUN_PRI) || (r.state == SLPREG_RUN_INT);

    a_ctrl_write_mask: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en |=> (r.ctrl == ($past(pwdata[7:0]) & SLPREG_CTRL_WMASK)))
        else $error("control write mask wrong");
    a_unimpl_zero: assert property (@(posedge pclk) disable iff (!presetn)
        (prdata[6] == 1'b0) && (prdata[3] == 1'b0 || paddr != SLPREG_CTRL_ADDR))
        else $error("unimplemented bits not zero");
    a_level_follow: assert property (@(posedge pclk) disable iff (!presetn)
        ultralow_wake_unit_enable && $stable(ultralow_wake_unit_enable)
        |-> r.level == $past(wake_comparator_in))
        else $error("level does not follow comparator");
    a_wdt_override: assert property (@(posedge pclk) disable iff (!presetn)
        (watchdog_config_mode != SLPREG_WDT_SOFT) |-> watchdog_enable)
        else $error("watchdog config not honoured");
    a_refs_kept: assert property (@(posedge pclk) disable iff (!presetn)
        (brownout_reset_enable || low_voltage_detect_enable) |-> references_on)
        else $error("references dropped");
    a_ultra_decode: assert property (@(posedge pclk) disable iff (!presetn)
        (r.state == SLPREG_RUN_PRI && sleep_request && r.ctrl[SLPREG_BIT_KEEP]
         && keep_avail) |=> regulator_ultralow)
        else $error("ultra mode not entered");
    a_mode_held: assert property (@(posedge pclk) disable iff (!presetn)
        in_sleep && $past(in_sleep) |-> $stable(r.mode))
        else $error("sleep mode changed");
    a_xtal_switch: assert property (@(posedge pclk) disable iff (!presetn)
        (r.state == SLPREG_RUN_INT && !sleep_request && crystal_startup_timer_done)
        |=> primary_clock_ready_status && !internal_oscillator_select)
        else $error("no switch to primary");
    a_wake_delay: assert property (@(posedge pclk) disable iff (!presetn)
        (r.state == SLPREG_SLEEP && wake_event && r.mode == SLPREG_REG_ULTRA)
        |=> !core_run [*8])
        else $error("ultra wake ran early");
    a_twospeed_off: assert property (@(posedge pclk) disable iff (!presetn)
        (r.state == SLPREG_RUN_PRI && !sleep_request && !two_speed_start_enable)
        |=> !internal_oscillator_select)
        else $error("two-speed used while disabled");

    c_sleep_ultra: cover property (@(posedge pclk) regulator_ultralow);
    c_sleep_low:   cover property (@(posedge pclk) regulator_standby);
    c_twospeed:    cover property (@(posedge pclk)
        internal_oscillator_select ##1 primary_clock_ready_status);
    c_wake_wait:   cover property (@(posedge pclk) cnt_busy ##1 cnt_done);
endmodule

/* verif/slpreg_xtal_model.sv */
// Crystal start-up timer model standing outside the sleep controller
`timescale 1ns/1ps
module slpreg_xtal_model #(
    parameter int START_CYC = 20
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic internal_oscillator_select,
    output logic      crystal_startup_timer_done
);
    int cnt;
    // Counts only while the core waits on the internal oscillator
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 0;
            crystal_startup_timer_done <= 1'h0;
        end else begin
            cnt <= internal_oscillator_select ? cnt + 1 : 0;
            crystal_startup_timer_done <= internal_oscillator_select && cnt == START_CYC - 1;
        end
    end
endmodule

/* verif/tb_slpreg_top.sv */
// Self-checking bench for the sleep, regulator and two-speed start controller
`timescale 1ns/1ps
module tb_slpreg_top
    import slpreg_pkg::*;
;
    logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic [1:0]  watchdog_config_mode = 2'h0;
    logic        regulator_enable_strap = 1'h1, keepalive_regulator_config = 1'h0;
    logic        two_speed_start_enable = 1'h0, brownout_reset_enable = 1'h0;
    logic        low_voltage_detect_enable = 1'h0, wake_comparator_in = 1'h0;
    logic        sleep_request = 1'h0, wake_event = 1'h0, reset_start = 1'h0;
    logic        power_managed_mode = 1'h0, pready, pslverr, se, crystal_startup_timer_done;
    logic        watchdog_enable, wake_current_sink_enable, ultralow_wake_unit_enable;
    logic        regulator_standby, regulator_ultralow, references_on, in_sleep;
    logic        internal_oscillator_select, primary_clock_ready_status, core_run;
    int          error_cnt = 0, n_tests = 0;

    slpreg_top u_slpreg_top (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .regulator_enable_strap, .keepalive_regulator_config, .watchdog_config_mode,
        .two_speed_start_enable, .brownout_reset_enable, .low_voltage_detect_enable,
        .wake_comparator_in, .sleep_request, .wake_event, .reset_start, .power_managed_mode,
        .crystal_startup_timer_done, .watchdog_enable, .wake_current_sink_enable,
        .ultralow_wake_unit_enable, .regulator_standby, .regulator_ultralow, .references_on,
        .internal_oscillator_select, .primary_clock_ready_status, .core_run, .in_sleep
    );
    slpreg_xtal_model u_slpreg_xtal_model (
        .pclk, .presetn, .internal_oscillator_select, .crystal_startup_timer_done
    );

    initial begin
        forever #2 pclk = ~pclk;
    end

    task automatic results();
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chkb(input string nm, input logic e, input logic g);
        chk(nm, {31'h0, e}, {31'h0, g});
    endtask
    task automatic hang(input string nm);
        chkb(nm, 1'h1, 1'h0);
        results();
    endtask
    // Holds the whole request until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        for (i = 0; i < 16; i++) begin
            @(posedge pclk);
            if (pready === 1'h1) break;
        end
        if (i == 16) hang("pready");
        q = prdata;
        se = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic pulse(input int k);
        @(posedge pclk);
        case (k)
            0: sleep_request <= 1'h1;
            1: wake_event <= 1'h1;
            default: reset_start <= 1'h1;
        endcase
        @(posedge pclk);
        sleep_request <= 1'h0;
        wake_event <= 1'h0;
        reset_start <= 1'h0;
        repeat (2) @(negedge pclk);
    endtask
    task automatic wait_pri();
        int n;
        for (n = 0; n < 64 && primary_clock_ready_status !== 1'h1; n++) @(negedge pclk);
        if (n == 64) hang("primary_ready");
    endtask
    // Mode m is {ultra, standby}; a late write must not disturb the held mode
    task automatic t_sleep(input logic [7:0] c, input logic st, input logic ke, input logic [1:0] m);
        int n;
        @(posedge pclk);
        regulator_enable_strap <= st;
        keepalive_regulator_config <= ke;
        apb(1'h1, SLPREG_CTRL_ADDR, {24'h0, c});
        pulse(0);
        chkb("in_sleep", 1'h1, in_sleep);
        chk("reg_mode", {30'h0, m}, {30'h0, regulator_ultralow, regulator_standby});
        apb(1'h1, SLPREG_CTRL_ADDR, 32'h0);
        @(negedge pclk);
        chk("held_mode", {30'h0, m}, {30'h0, regulator_ultralow, regulator_standby});
        apb(1'h0, SLPREG_STATUS_ADDR, 32'h0);
        chk("sleep_status", {28'h0, m, 2'b10}, q);
        if (m[1]) begin
            chkb("refs_off", 1'h0, references_on);
            @(posedge pclk);
            low_voltage_detect_enable <= 1'h1;
            repeat (2) @(negedge pclk);
            chkb("refs_lvd", 1'h1, references_on);
        end
        pulse(1);
        for (n = 0; n < 70000 && core_run !== 1'h1; n++) @(negedge pclk);
        if (n == 70000) hang("core_run");
        chkb("wake_wait", 1'h1, m[1] ? n > SLPREG_WAKE_CYC - 4 && n < SLPREG_WAKE_CYC + 2 : n == 0);
        @(posedge pclk);
        low_voltage_detect_enable <= 1'h0;
    endtask
    task automatic t_regs();
        apb(1'h0, SLPREG_CTRL_ADDR, 32'h0);
        chk("ctrl_reset", {24'h0, SLPREG_CTRL_RESET}, q);
        apb(1'h1, SLPREG_CTRL_ADDR, 32'hFFFFFFFF);
        apb(1'h0, SLPREG_CTRL_ADDR, 32'h0);
        chk("ctrl_mask", 32'h97, q);
        chkb("sink", 1'h1, wake_current_sink_enable);
        chkb("wake_unit", 1'h1, ultralow_wake_unit_enable);
        chkb("wdt_soft", 1'h1, watchdog_enable);
        wake_comparator_in <= 1'h1;
        apb(1'h0, SLPREG_CTRL_ADDR, 32'h0);
        chk("ctrl_level", 32'hB7, q);
        apb(1'h1, SLPREG_CTRL_ADDR, 32'h0);
        apb(1'h0, SLPREG_CTRL_ADDR, 32'h0);
        chk("level_off", 32'h0, q);
        chkb("wdt_off", 1'h0, watchdog_enable);
        watchdog_config_mode <= 2'h1;
        apb(1'h0, 8'h08, 32'h0);
        chkb("unmapped", 1'h1, se);
        chkb("wdt_cfg", 1'h1, watchdog_enable);
        watchdog_config_mode <= SLPREG_WDT_SOFT;
        apb(1'h1, SLPREG_STATUS_ADDR, 32'h0);
        apb(1'h0, SLPREG_STATUS_ADDR, 32'h0);
        chk("status", 32'h1, q);
    endtask
    task automatic t_two();
        two_speed_start_enable <= 1'h1;
        t_sleep(8'h00, 1'h1, 1'h0, 2'h0);
        chkb("int_osc", 1'h1, internal_oscillator_select);
        chkb("pri_clear", 1'h0, primary_clock_ready_status);
        wait_pri();
        pulse(2);
        chkb("int_reset", 1'h1, internal_oscillator_select);
        wait_pri();
        @(posedge pclk);
        power_managed_mode <= 1'h1;
        t_sleep(8'h00, 1'h1, 1'h0, 2'h0);
        chkb("pm_primary", 1'h1, primary_clock_ready_status);
        @(posedge pclk);
        power_managed_mode <= 1'h0;
        two_speed_start_enable <= 1'h0;
        pulse(2);
        chkb("no_two_speed", 1'h0, internal_oscillator_select);
    endtask

    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'h1;
        t_regs();
        t_sleep(8'h00, 1'h1, 1'h0, 2'h0);
        t_sleep(8'h80, 1'h1, 1'h0, 2'h1);
        t_sleep(8'h90, 1'h1, 1'h1, 2'h1);
        t_sleep(8'h90, 1'h0, 1'h0, 2'h1);
        t_sleep(8'h90, 1'h1, 1'h0, 2'h2);
        t_two();
        results();
    end
endmodule
